//--- dv/sfr_host.sv
// sfr_host: behavioural serial master for the frame readout slave
// assumes a 100 MHz bench clock; serial period is eight clocks, 80 ns
`timescale 1ns/1ps
`default_nettype none
module sfr_host (
    input wire logic clk_i,
    input wire logic sdo_i,
    output logic sclk_o,
    output logic cs_n_o,
    output logic sdi_o
);
    // ==========================================================
    // pins idle high; 12.5 MHz is far below 40 MHz
    initial begin
        sclk_o = 1'b1;
        cs_n_o = 1'b1;
        sdi_o = 1'b1;
    end

    // ==========================================================
    // select without clocking, used to watch the idle output level
    task automatic select(input logic cs_n);
        @(negedge clk_i);
        cs_n_o = cs_n;
    endtask

    // ==========================================================
    // one word, msb first: drive on the fall, sample on the rise
    task automatic xfer(input logic [31:0] tx, input int nbits, output logic [31:0] rx);
        rx = '0;
        @(negedge clk_i);
        cs_n_o = 1'b0;
        repeat (4) @(negedge clk_i);
        for (int i = nbits - 1; i >= 0; i--) begin
            sclk_o = 1'b0;
            sdi_o = tx[i];
            repeat (4) @(negedge clk_i);
            sclk_o = 1'b1;
            rx = {rx[30:0], sdo_i};
            repeat (4) @(negedge clk_i);
        end
        cs_n_o = 1'b1;
        // released line must not keep showing the last bit
        sdi_o = ~sdi_o;
    endtask
endmodule
`default_nettype wire

//--- dv/tb_top.sv
// tb_top: self-checking bench for sfr_readout with a serial master model
// assumes the master model above; frame words stay constant during the run
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic load = 1'b0;
    logic [9:0][23:0] words;
    wire logic sclk, cs_n, sdi, sdo, oe_n, rdy_n, tick;
    // no pull-up: a released line shows the inverse so a late sample is caught
    wire logic sdo_line = oe_n ? ~sdo : sdo;
    int mismatches = 0;
    int check_count = 0;
    int cycles = 0;
    logic [31:0] rx;

    always #5 clk = ~clk;

    sfr_host host (.clk_i(clk), .sdo_i(sdo_line), .sclk_o(sclk), .cs_n_o(cs_n), .sdi_o(sdi));
    sfr_readout dut (.clk_i(clk), .nrst_i(nrst), .sclk_i(sclk), .cs_n_i(cs_n), .sdi_i(sdi),
        .sdo_o(sdo), .sdo_oe_n_o(oe_n), .frame_ready_n_o(rdy_n), .mclk_tick_o(tick),
        .frame_load_i(load), .frame_words_i(words));

    // ==========================================================
    // reporting
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask

    task automatic wrap_up();
        if (mismatches == 0 && check_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 70000) begin
            mismatches++;
            wrap_up();
        end
    end

    // ==========================================================
    // helpers: bounded wait on frame-ready, one converted frame
    task automatic wait_rdy(input logic lvl);
        for (int n = 0; n < 4000 && rdy_n !== lvl; n++) @(negedge clk);
        repeat (8) @(negedge clk);
    endtask

    task automatic new_frame();
        repeat (400) @(negedge clk);
        load = 1'b1;
        @(negedge clk);
        load = 1'b0;
        wait_rdy(1'b0);
    endtask

    // ==========================================================
    // scenarios
    task automatic t_init();
        repeat (6) @(negedge clk);
        check({oe_n, rdy_n, tick}, 32'h6);
        nrst = 1'b1;
        repeat (20) @(negedge clk);
        check(rdy_n, 32'h1);
        wait_rdy(1'b0);
        check(rdy_n, 32'h0);
    endtask

    task automatic t_regread();
        host.xfer({1'b1, 7'h11, 24'h0}, 32, rx);
        host.xfer({1'b1, sfr_pkg::ADDR_HEADER, 24'h0}, 32, rx);
        check(rx, {1'b0, 7'h11, words[1]});
        host.xfer(32'h0, 32, rx);
        check(rx[31:24], 32'h40);
        host.xfer({1'b0, sfr_pkg::ADDR_MAIN_CTRL, 24'h000004}, 32, rx);
        // no frame converted yet, so the buffered word is still empty
        check(rx, {1'b0, 7'h11, 24'h000000});
        wait_rdy(1'b1);
        check(rdy_n, 32'h1);
    endtask

    task automatic t_frame();
        new_frame();
        check(rdy_n, 32'h0);
        host.xfer(32'hffffffff, 10, rx);
        host.xfer({1'b1, sfr_pkg::ADDR_HEADER, 24'h0}, 32, rx);
        for (int i = 0; i < 10; i++) begin
            check(rdy_n, 32'h0);
            host.xfer(32'h0, 32, rx);
            if (i == 0) check(rx[31:24], 32'h40);
            else check(rx, {1'b0, sfr_pkg::SRC_ADDR[i], words[i]});
        end
        repeat (8) @(negedge clk);
        check(rdy_n, 32'h1);
        host.select(1'b0);
        repeat (12) @(negedge clk);
        check({oe_n, sdo}, 32'h1);
        new_frame();
        check({oe_n, sdo}, 32'h0);
        host.select(1'b1);
        repeat (12) @(negedge clk);
        check(oe_n, 32'h1);
    endtask

    // narrow rate, then a mask that leaves only the checksum word
    task automatic t_narrow();
        logic [3:0] s;
        host.xfer({1'b0, sfr_pkg::ADDR_FRAME_CTRL, 24'hffc020}, 32, rx);
        host.xfer({1'b1, sfr_pkg::ADDR_HEADER, 24'h0}, 32, rx);
        for (int i = 0; i < 13; i++) begin
            s = sfr_pkg::NARROW_SRC[i];
            host.xfer(32'h0, 16, rx);
            if (i > 0 && sfr_pkg::NARROW_LO[i]) check(rx[15:0], {words[s][7:0], 8'h00});
            else if (i > 0) check(rx[15:0], words[s][23:8]);
        end
        repeat (8) @(negedge clk);
        check(rdy_n, 32'h1);
        host.xfer({16'h0, 1'b0, sfr_pkg::ADDR_FRAME_CTRL, 8'h80}, 16, rx);
        new_frame();
        host.xfer({1'b1, sfr_pkg::ADDR_HEADER, 24'h0}, 32, rx);
        host.xfer(32'h0, 32, rx);
        check(rx, {1'b0, 7'h41, words[9]});
        repeat (8) @(negedge clk);
        check(rdy_n, 32'h1);
    endtask

    // header and checksum only, header repeated until ready, one load in two kept
    task automatic t_skip();
        host.xfer({1'b0, sfr_pkg::ADDR_FRAME_CTRL, 24'h804041}, 32, rx);
        host.xfer({1'b1, sfr_pkg::ADDR_HEADER, 24'h0}, 32, rx);
        host.xfer(32'h0, 32, rx);
        check({rx[31:24], rx[22]}, {8'hc0, 1'b0});
        @(negedge clk);
        load = 1'b1;
        @(negedge clk);
        load = 1'b0;
        repeat (20) @(negedge clk);
        check(rdy_n, 32'h1);
        new_frame();
        check(rdy_n, 32'h0);
        host.xfer(32'h0, 32, rx);
        check({rx[31:24], rx[22]}, {8'h40, 1'b1});
        host.xfer({1'b1, sfr_pkg::ADDR_MAIN_CTRL, 24'h0}, 32, rx);
        check(rx, {1'b0, 7'h41, words[9]});
        host.xfer({1'b1, sfr_pkg::ADDR_HEADER, 24'h0}, 32, rx);
        check(rx, {1'b0, sfr_pkg::ADDR_MAIN_CTRL, 24'h000004});
        check(rdy_n, 32'h1);
    endtask

    task automatic t_tick(input logic [23:0] ctl, input int lo, input int hi);
        int n;
        n = 0;
        host.xfer({1'b0, sfr_pkg::ADDR_MAIN_CTRL, ctl}, 32, rx);
        repeat (200) @(negedge clk);
        repeat (10000) begin
            @(negedge clk);
            if (tick === 1'b1) n++;
        end
        check(32'(n >= lo && n <= hi), 32'h1);
    endtask

    initial begin
        for (int i = 0; i < 10; i++) words[i] = 24'h5a3c81 + 24'(i * 24'h110b07);
        t_init();
        t_regread();
        t_frame();
        t_narrow();
        t_skip();
        t_tick(24'h000004, 101, 104);
        t_tick(24'h00000c, 203, 206);
        wrap_up();
    end
endmodule
`default_nettype wire

//--- hdl/sfr_mclk_tick.sv
// sfr_mclk_tick: internal master clock as a one-cycle enable
// assumes the system clock is much faster than the master clock
`timescale 1ns/1ps
`default_nettype none
module sfr_mclk_tick #(
    parameter int ACC_W = sfr_pkg::TICK_ACC_W
) (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic fast_i,
    output logic tick_o
);
    // ==========================================================
    // fractional accumulator: average rate slightly low from the truncated step, single tick jitters by a cycle
    if (ACC_W < 8 || ACC_W > 24) begin : g_chk
        $error("sfr_mclk_tick: ACC_W out of range");
    end

    localparam logic [ACC_W:0] STEP_F = (ACC_W + 1)'(sfr_pkg::TICK_STEP_FAST);
    localparam logic [ACC_W:0] STEP_S = (ACC_W + 1)'(sfr_pkg::TICK_STEP_SLOW);

    logic [ACC_W-1:0] acc_q;
    logic tick_q;
    wire logic [ACC_W:0] step = fast_i ? STEP_F : STEP_S;
    wire logic [ACC_W:0] sum = {1'b0, acc_q} + step;

    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            acc_q <= '0;
            tick_q <= 1'b0;
        end else begin
            acc_q <= sum[ACC_W-1:0];
            tick_q <= sum[ACC_W];
        end
    end

    assign tick_o = tick_q;
endmodule
`default_nettype wire

//--- hdl/sfr_pin_if.sv
// sfr_pin_if: synchronised link levels and edge pulses, system clock domain
// assumes the producer has already passed every pin through two flip-flops
`timescale 1ns/1ps
`default_nettype none
interface sfr_pin_if;
    logic sclk_rise;
    logic sclk_fall;
    logic cs_fall;
    logic cs_rise;
    logic cs_n;
    logic sdi;
    modport src (output sclk_rise, output sclk_fall, output cs_fall, output cs_rise,
                 output cs_n, output sdi);
    modport dst (input sclk_rise, input sclk_fall, input cs_fall, input cs_rise,
                 input cs_n, input sdi);
endinterface
`default_nettype wire

//--- hdl/sfr_pin_sync.sv
// sfr_pin_sync: two-flop synchronisers and edge finders for the serial pins
// assumes the serial clock is at least four system clocks per half period
`timescale 1ns/1ps
`default_nettype none
module sfr_pin_sync (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic sclk_i,
    input wire logic cs_n_i,
    input wire logic sdi_i,
    sfr_pin_if.src pins
);
    // ==========================================================
    // synchronisers: stage one feeds stage two only
    logic [2:0] meta_q;
    logic [2:0] sync_q;
    logic [1:0] hist_q;

    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            meta_q <= 3'h7;
            sync_q <= 3'h7;
            hist_q <= 2'h3;
        end else begin
            meta_q <= {sdi_i, cs_n_i, sclk_i};
            sync_q <= meta_q;
            hist_q <= sync_q[1:0];
        end
    end

    // ==========================================================
    // edges; sdi from the same stage keeps it aligned with sclk
    assign pins.sclk_rise = sync_q[0] & ~hist_q[0];
    assign pins.sclk_fall = ~sync_q[0] & hist_q[0];
    assign pins.cs_fall = ~sync_q[1] & hist_q[1];
    assign pins.cs_rise = sync_q[1] & ~hist_q[1];
    assign pins.cs_n = sync_q[1];
    assign pins.sdi = sync_q[2];
endmodule
`default_nettype wire

//--- hdl/sfr_pkg.sv
// sfr_pkg: constants, address map and field layout of the frame readout slave
// assumes a 100 MHz system clock; the link is sampled, never used as a clock
package sfr_pkg;

    // ==========================================================
    // clocks and timing
    localparam int CLK_KHZ = 100000;
    localparam int MCLK_FAST_KHZ = 2048;
    localparam int MCLK_SLOW_KHZ = 1024;
    localparam int TICK_ACC_W = 16;
    localparam int TICK_STEP_FAST = (MCLK_FAST_KHZ * (2 ** TICK_ACC_W)) / CLK_KHZ;
    localparam int TICK_STEP_SLOW = (MCLK_SLOW_KHZ * (2 ** TICK_ACC_W)) / CLK_KHZ;
    localparam logic [1:0] HANDSHAKE_TICKS = 2'd3;
    localparam logic [4:0] INIT_TICKS = 5'h10;

    // ==========================================================
    // register addresses
    localparam logic [6:0] ADDR_NOP = 7'h00;
    localparam logic [6:0] ADDR_MAIN_CTRL = 7'h01;
    localparam logic [6:0] ADDR_FRAME_CTRL = 7'h0a;
    localparam logic [6:0] ADDR_HEADER = 7'h40;
    // frame word sources in wide order: header .. checksum
    localparam logic [9:0][6:0] SRC_ADDR = {7'h41, 7'h06, 7'h1d, 7'h1c, 7'h1b,
                                            7'h1a, 7'h13, 7'h12, 7'h11, 7'h40};

    // ==========================================================
    // field layout and reset values
    localparam logic [23:0] MAIN_CTRL_RST = 24'h000000;
    localparam logic [23:0] FRAME_CTRL_RST = 24'hffc000;
    localparam int CNV_BIT = 2;
    localparam int HP_BIT = 3;
    localparam int RPT_BIT = 6;
    localparam int SKIP_LSB = 0;
    localparam int RATE_LSB = 4;
    localparam int WEN_LSB = 14;
    localparam int HDR_READY_BIT = 22;
    localparam logic [1:0] RATE_128K = 2'h2;

    // ==========================================================
    // narrow (16-bit) frame: slot to source, and lower-half slots
    localparam int WORDS_WIDE = 10;
    localparam int WORDS_NARROW = 13;
    localparam logic [12:0][3:0] NARROW_SRC = {4'h9, 4'h8, 4'h7, 4'h6, 4'h6, 4'h5,
                                               4'h5, 4'h4, 4'h4, 4'h3, 4'h2, 4'h1,
                                               4'h0};
    localparam logic [12:0] NARROW_LO = 13'h02a0;

    typedef enum logic [1:0] {SFR_IDLE, SFR_REG, SFR_FRAME} sfr_mode_e;

endpackage

//--- hdl/sfr_readout.sv
// sfr_readout: serial slave for frame readout, register reads and frame-ready
// assumes frame_load_i pulses once per converted frame on the system clock
`timescale 1ns/1ps
`default_nettype none
module sfr_readout #(
    parameter int NSRC = sfr_pkg::WORDS_WIDE
) (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic sclk_i,
    input wire logic cs_n_i,
    input wire logic sdi_i,
    output logic sdo_o,
    output logic sdo_oe_n_o,
    output logic frame_ready_n_o,
    output logic mclk_tick_o,
    input wire logic frame_load_i,
    input wire logic [9:0][23:0] frame_words_i
);
    if (NSRC != sfr_pkg::WORDS_WIDE) begin : g_chk
        $error("sfr_readout: NSRC must match the frame layout");
    end

    // ==========================================================
    // pins and master clock
    sfr_pin_if pins ();
    logic tick;
    logic [23:0] main_ctrl_q;
    logic [23:0] frame_ctrl_q;

    sfr_pin_sync u_sync (
        .clk_i(clk_i),
        .nrst_i(nrst_i),
        .sclk_i(sclk_i),
        .cs_n_i(cs_n_i),
        .sdi_i(sdi_i),
        .pins(pins.src)
    );

    sfr_mclk_tick u_tick (
        .clk_i(clk_i),
        .nrst_i(nrst_i),
        .fast_i(main_ctrl_q[sfr_pkg::HP_BIT]),
        .tick_o(tick)
    );

    // ==========================================================
    // state
    sfr_pkg::sfr_mode_e mode_q;
    logic [3:0] slot_q;
    logic [31:0] tx_q;
    logic [31:0] rx_q;
    logic len32_q;
    logic [4:0] cnt_q;
    logic sdo_q;
    logic oe_n_q;
    logic rdy_n_q;
    logic avail_q;
    logic rel_busy_q;
    logic [1:0] rel_cnt_q;
    logic [1:0] skip_cnt_q;
    logic [4:0] init_cnt_q;
    logic init_done_q;
    logic [9:0][23:0] snap_q;
    logic [1:0] hs_ticks_q;

    wire logic cnv = main_ctrl_q[sfr_pkg::CNV_BIT];
    wire logic rpt = frame_ctrl_q[sfr_pkg::RPT_BIT];
    wire logic [9:0] wen = frame_ctrl_q[sfr_pkg::WEN_LSB +: 10];
    wire logic [1:0] skip = frame_ctrl_q[sfr_pkg::SKIP_LSB +: 2];
    wire logic narrow = frame_ctrl_q[sfr_pkg::RATE_LSB +: 2] == sfr_pkg::RATE_128K;
    wire logic in_frame = mode_q == sfr_pkg::SFR_FRAME;

    // ==========================================================
    // frame layout helpers
    function automatic logic [3:0] f_src(input logic [3:0] s);
        f_src = narrow ? sfr_pkg::NARROW_SRC[s] : s;
    endfunction

    // lowest enabled slot at or above start; msb flags a hit
    function automatic logic [4:0] f_scan(input logic [4:0] start);
        logic [4:0] r;
        int n;
        r = 5'h00;
        n = narrow ? sfr_pkg::WORDS_NARROW : sfr_pkg::WORDS_WIDE;
        for (int i = 12; i >= 0; i--) begin
            if (i < n && 5'(i) >= start && wen[f_src(4'(i))]) begin
                r = {1'b1, 4'(i)};
            end
        end
        f_scan = r;
    endfunction

    function automatic logic [31:0] f_word(input logic [3:0] s);
        logic [3:0] src;
        logic [23:0] d;
        src = f_src(s);
        d = snap_q[src];
        if (src == 4'h0) begin
            d[sfr_pkg::HDR_READY_BIT] = avail_q;
        end
        if (narrow) begin
            f_word = sfr_pkg::NARROW_LO[s] ? {16'h0000, d[7:0], 8'h00}
                                           : {16'h0000, d[23:8]};
        end else begin
            f_word = {1'b0, sfr_pkg::SRC_ADDR[src], d};
        end
    endfunction

    function automatic logic [23:0] f_reg(input logic [6:0] a);
        logic [23:0] v;
        v = 24'h000000;
        for (int k = 0; k < 10; k++) begin
            if (a == sfr_pkg::SRC_ADDR[k]) begin
                v = frame_words_i[k];
            end
        end
        if (a == sfr_pkg::ADDR_MAIN_CTRL) begin
            v = main_ctrl_q;
        end
        if (a == sfr_pkg::ADDR_FRAME_CTRL) begin
            v = frame_ctrl_q;
        end
        f_reg = v;
    endfunction

    // ==========================================================
    // word decode at the last rising edge of a word
    wire logic [4:0] len_last = len32_q ? 5'h1f : 5'h0f;
    wire logic shift_in = pins.sclk_rise & ~pins.cs_n;
    wire logic shift_out = pins.sclk_fall & ~pins.cs_n;
    wire logic word_end = shift_in & (cnt_q == len_last);
    wire logic [31:0] rx_word = {rx_q[30:0], pins.sdi};
    // a narrow word lands in the upper half so decode stays common
    wire logic [31:0] cmd = len32_q ? rx_word : {rx_word[15:0], 16'h0000};
    wire logic cmd_rd = cmd[31];
    wire logic [6:0] cmd_addr = cmd[30:24];
    wire logic cmd_hdr = cmd_rd & (cmd_addr == sfr_pkg::ADDR_HEADER);
    wire logic cmd_reg = cmd_rd & ~cmd_hdr;
    wire logic cmd_nop = ~cmd_rd & (cmd_addr == sfr_pkg::ADDR_NOP);
    wire logic cmd_wr = ~cmd_rd & ~cmd_nop;

    // the scan functions read module state, which only a process is sensitive to
    logic [4:0] first_scan;
    logic [4:0] next_scan;
    always_comb begin
        first_scan = f_scan(5'h00);
        next_scan = f_scan({1'b0, slot_q} + 5'h01);
    end
    wire logic slot_last = ~next_scan[4];
    wire logic hold_hdr = rpt & (slot_q == 4'h0) & ~avail_q;
    wire logic [3:0] adv_slot = hold_hdr ? 4'h0 : (next_scan[4] ? next_scan[3:0]
                                                                 : first_scan[3:0]);
    // any command other than a nop or a header read drops out of framing
    wire sfr_pkg::sfr_mode_e nx_mode = cmd_hdr ? sfr_pkg::SFR_FRAME :
                                       cmd_reg ? sfr_pkg::SFR_REG :
                                       (cmd_nop & in_frame) ? sfr_pkg::SFR_FRAME
                                                          : sfr_pkg::SFR_IDLE;
    wire logic [3:0] nx_slot = cmd_hdr ? first_scan[3:0] : adv_slot;
    wire logic nx_frame = nx_mode == sfr_pkg::SFR_FRAME;
    logic [31:0] nx_tx;
    always_comb begin
        nx_tx = 32'h00000000;
        if (nx_frame) begin
            nx_tx = f_word(nx_slot);
        end else if (cmd_reg) begin
            nx_tx = {1'b0, cmd_addr, f_reg(cmd_addr)};
        end
    end
    wire logic nx_len32 = ~(nx_frame & narrow);

    // the header's first bit shows readiness while no clock runs
    wire logic first_bit = (in_frame & (slot_q == 4'h0)) ? rdy_n_q : tx_q[len_last];
    wire logic [4:0] bit_idx = len_last - cnt_q;
    wire logic last_fall = shift_out & in_frame & slot_last & (cnt_q == len_last)
                         & avail_q;

    // ==========================================================
    // buffer, skip, handshake and readiness
    wire logic skip_hit = skip_cnt_q == skip;
    wire logic accept = frame_load_i & cnv & skip_hit & ~avail_q & ~rel_busy_q
                      & init_done_q;
    wire logic rdy_n_d = ~init_done_q | (cnv & ~avail_q);

    // ==========================================================
    // serial engine
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            cnt_q <= 5'h00;
            rx_q <= 32'h00000000;
        end else begin
            if (pins.cs_rise || pins.cs_fall) begin
                cnt_q <= 5'h00;
            end else if (shift_in) begin
                cnt_q <= word_end ? 5'h00 : cnt_q + 5'h01;
            end
            if (shift_in) begin
                rx_q <= rx_word;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            sdo_q <= 1'b1;
            oe_n_q <= 1'b1;
        end else begin
            oe_n_q <= pins.cs_n;
            if (pins.cs_fall) begin
                sdo_q <= first_bit;
            end else if (shift_out) begin
                sdo_q <= (cnt_q == 5'h00) ? first_bit : tx_q[bit_idx];
            end else if (cnt_q == 5'h00 && in_frame && slot_q == 4'h0) begin
                sdo_q <= rdy_n_q;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            mode_q <= sfr_pkg::SFR_IDLE;
            slot_q <= 4'h0;
            tx_q <= 32'h00000000;
            len32_q <= 1'b1;
        end else if (word_end) begin
            mode_q <= nx_mode;
            slot_q <= nx_slot;
            tx_q <= nx_tx;
            len32_q <= nx_len32;
        end else if (in_frame && slot_q == 4'h0 && cnt_q == 5'h00) begin
            // header rebuilt until its first rise so its ready bit stays current
            tx_q <= f_word(4'h0);
        end
    end

    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            main_ctrl_q <= sfr_pkg::MAIN_CTRL_RST;
            frame_ctrl_q <= sfr_pkg::FRAME_CTRL_RST;
        end else if (word_end && cmd_wr) begin
            if (cmd_addr == sfr_pkg::ADDR_MAIN_CTRL) begin
                main_ctrl_q <= cmd[23:0];
            end
            if (cmd_addr == sfr_pkg::ADDR_FRAME_CTRL) begin
                frame_ctrl_q <= cmd[23:0];
            end
        end
    end

    // ==========================================================
    // core side
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            avail_q <= 1'b0;
            snap_q <= '0;
            skip_cnt_q <= 2'h0;
        end else begin
            if (accept) begin
                avail_q <= 1'b1;
                snap_q <= frame_words_i;
            end else if (last_fall) begin
                avail_q <= 1'b0;
            end
            if (frame_load_i && cnv) begin
                skip_cnt_q <= skip_hit ? 2'h0 : skip_cnt_q + 2'h1;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            rel_busy_q <= 1'b0;
            rel_cnt_q <= 2'h0;
            hs_ticks_q <= 2'h0;
        end else if (last_fall) begin
            rel_busy_q <= 1'b1;
            rel_cnt_q <= 2'h0;
            hs_ticks_q <= 2'h0;
        end else begin
            if (rel_busy_q && tick) begin
                rel_busy_q <= rel_cnt_q != sfr_pkg::HANDSHAKE_TICKS - 2'h1;
                rel_cnt_q <= rel_cnt_q + 2'h1;
            end
            // checker count: ticks since the frame ended, saturating
            if (tick && hs_ticks_q != 2'h3) begin
                hs_ticks_q <= hs_ticks_q + 2'h1;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            init_cnt_q <= 5'h00;
            init_done_q <= 1'b0;
            rdy_n_q <= 1'b1;
        end else begin
            if (tick && !init_done_q) begin
                init_cnt_q <= init_cnt_q + 5'h01;
                init_done_q <= init_cnt_q == sfr_pkg::INIT_TICKS - 5'h01;
            end
            rdy_n_q <= rdy_n_d;
        end
    end

    assign sdo_o = sdo_q;
    assign sdo_oe_n_o = oe_n_q;
    assign frame_ready_n_o = rdy_n_q;
    assign mclk_tick_o = tick;

    // ==========================================================
    // checks
    property p_oe_release;
        @(posedge clk_i) disable iff (!nrst_i) pins.cs_n |=> sdo_oe_n_o;
    endproperty
    a_oe_release: assert property (p_oe_release) else $error("sdo driven with cs high");

    property p_ready_clear;
        @(posedge clk_i) disable iff (!nrst_i) (last_fall && cnv) |=> ##1 frame_ready_n_o;
    endproperty
    a_ready_clear: assert property (p_ready_clear) else $error("ready kept after frame");

    property p_handshake;
        @(posedge clk_i) disable iff (!nrst_i)
            (rel_busy_q || $fell(rel_busy_q)) |-> (hs_ticks_q == 2'h3) == !rel_busy_q;
    endproperty
    a_handshake: assert property (p_handshake) else $error("handshake not three ticks");

    property p_no_cnv_ready;
        @(posedge clk_i) disable iff (!nrst_i)
            (init_done_q && !cnv) |=> !frame_ready_n_o;
    endproperty
    a_no_cnv_ready: assert property (p_no_cnv_ready) else $error("busy without cnv");

    property p_full_ready;
        @(posedge clk_i) disable iff (!nrst_i)
            (init_done_q && cnv && avail_q) |=> !frame_ready_n_o;
    endproperty
    a_full_ready: assert property (p_full_ready) else $error("full buffer not ready");

    property p_read_word;
        @(posedge clk_i) disable iff (!nrst_i)
            (word_end && cmd_reg) |=> len32_q && mode_q == sfr_pkg::SFR_REG
                                     && tx_q[30:24] == $past(cmd_addr);
    endproperty
    a_read_word: assert property (p_read_word) else $error("bad read answer word");

    property p_hdr_restart;
        @(posedge clk_i) disable iff (!nrst_i)
            (word_end && cmd_hdr) |=> in_frame && slot_q == $past(first_scan[3:0]);
    endproperty
    a_hdr_restart: assert property (p_hdr_restart) else $error("header read no restart");

    property p_init_busy;
        @(posedge clk_i) disable iff (!nrst_i) !init_done_q |=> frame_ready_n_o;
    endproperty
    a_init_busy: assert property (p_init_busy) else $error("ready during init");

    property p_partial;
        @(posedge clk_i) disable iff (!nrst_i) pins.cs_rise |=> cnt_q == 5'h00;
    endproperty
    a_partial: assert property (p_partial) else $error("partial word kept");

    property p_wide_tag;
        @(posedge clk_i) disable iff (!nrst_i)
            (in_frame && len32_q && !narrow) |-> tx_q[30:24] == sfr_pkg::SRC_ADDR[slot_q];
    endproperty
    a_wide_tag: assert property (p_wide_tag) else $error("frame word tag wrong");

    c_frame_done: cover property (@(posedge clk_i) disable iff (!nrst_i) last_fall);
    c_reg_read: cover property (@(posedge clk_i) disable iff (!nrst_i) word_end && cmd_reg);
    c_hdr_hold: cover property (@(posedge clk_i) disable iff (!nrst_i) word_end && hold_hdr);
endmodule
`default_nettype wire
